// [rtl/amc_i2c_master.sv]
/*
  Two-wire bus master that programs and polls the amplifier's control port.
  Assumes pull-ups on both wires and the device's register map 0x00..0x0F.
*/
// Function
// - Bus bit rate stays at 100 kbps.
// - Bytes are eight bits, MSB first.
// - Receiver acknowledges in ninth clock period.
// - SDA fall/rise with SCL high: start/stop.
// - Master changes SDA only while SCL low, except for start, repeated start and stop.
// - Start, 7-bit address, direction, then ack.
// - Any number of bytes per transfer; this master moves one data byte per transfer.
// - Direction bit zero means write.
// - Random write: address, register, data, stop.
// - After power-on reset, master re-initialises; this master only flags it, raising reinit_needed on any NACK.
// - Load dump shuts down; master restarts; this master has no load-dump handling beyond reinit_needed on a NACK.
// - Read: register write, repeated start, NACK.
`timescale 1ns/1ps
`default_nettype none
module amc_i2c_master
  import amc_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       cmd_valid,
  output logic            cmd_ready,
  input  wire logic [1:0] cmd_op,
  input  wire logic [1:0] cmd_dev_sel,
  input  wire logic [7:0] cmd_reg,
  input  wire logic [7:0] cmd_wdata,
  output logic            rsp_valid,
  output logic [7:0]      rsp_rdata,
  output logic            rsp_nack,
  input  wire logic       scl_i,
  output logic            scl_o,
  output logic            scl_oe,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe,
  output logic            reinit_needed
);
  // ************************************************************
  // State
  // ************************************************************
  typedef enum logic [7:0] {
    ST_IDLE  = 8'b0000_0001,
    ST_START = 8'b0000_0010,
    ST_TX    = 8'b0000_0100,
    ST_ACK   = 8'b0000_1000,
    ST_RX    = 8'b0001_0000,
    ST_MACK  = 8'b0010_0000,
    ST_RSTRT = 8'b0100_0000,
    ST_STOP  = 8'b1000_0000
  } amc_state_t;

  amc_state_t state, next_state;
  logic [1:0] qtr, next_qtr;
  logic [3:0] bitn, next_bitn;
  logic [1:0] stage, next_stage;   // 0 addr, 1 reg, 2 data/addr-read, 3 rx data
  logic [7:0] shreg, next_shreg;
  logic       is_read, next_is_read;
  logic       scl_low, next_scl_low;
  logic       sda_low, next_sda_low;
  logic [7:0] rdata, next_rdata;
  logic       rvalid, next_rvalid;
  logic       nack, next_nack;
  logic [1:0] scl_sync, sda_sync;
  logic       tick;

  function automatic logic [7:0] addr_byte(input logic [1:0] sel, input logic dir);
    addr_byte = {DEV_ADDR_BASE, sel, dir};
  endfunction

  amc_phase_gen u_phase (
    .core_clk (core_clk),
    .rst      (rst),
    .run      (state != ST_IDLE),
    .tick     (tick)
  );

  // Synchronise the wires before anything looks at them
  always_ff @(posedge core_clk) begin
    if (rst) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
    end else begin
      scl_sync <= {scl_sync[0], scl_i};
      sda_sync <= {sda_sync[0], sda_i};
    end
  end

  // ************************************************************
  // Sequencer: each bit is four quarter ticks, SDA moves in quarter 0 and, for restart and stop, in quarter 2
  // ************************************************************
  always_comb begin
    next_state   = state;
    next_qtr     = qtr;
    next_bitn    = bitn;
    next_stage   = stage;
    next_shreg   = shreg;
    next_is_read = is_read;
    next_scl_low = scl_low;
    next_sda_low = sda_low;
    next_rdata   = rdata;
    next_rvalid  = 1'b0;
    next_nack    = nack;
    case (state)
      ST_IDLE: begin
        next_scl_low = 1'b0;
        next_sda_low = 1'b0;
        if (cmd_valid) begin
          next_is_read = (cmd_op == AMC_CMD_READ);
          next_shreg   = addr_byte(cmd_dev_sel, DIR_WRITE);
          next_stage   = 2'h0;
          next_qtr     = 2'h0;
          next_nack    = 1'b0;
          next_state   = ST_START;
        end
      end
      ST_START, ST_RSTRT: begin
        if (tick) begin
          next_qtr = qtr + 2'h1;
          // Restart first releases SDA with SCL low, then raises SCL
          if (qtr == 2'h0) begin
            next_sda_low = (state == ST_START);
          end
          if (qtr == 2'h1) begin
            next_scl_low = 1'b0;
          end
          if (qtr == 2'h2) begin
            next_sda_low = 1'b1; // Restart: SDA falls while SCL high; start already pulled it low in quarter 0
          end
          if (qtr == 2'h3) begin
            next_scl_low = 1'b1;
            next_bitn    = BYTE_BITS;
            next_state   = ST_TX;
          end
        end
      end
      ST_TX, ST_ACK, ST_RX, ST_MACK: begin
        if (tick) begin
          next_qtr = qtr + 2'h1;
          if (qtr == 2'h0) begin
            // Data changes only with SCL low
            case (state)
              ST_TX:   next_sda_low = !shreg[7];
              ST_MACK: next_sda_low = 1'b0; // Single byte: NACK
              default: next_sda_low = 1'b0;
            endcase
          end
          if (qtr == 2'h1) begin
            next_scl_low = 1'b0;
          end
          if (qtr == 2'h2) begin
            if (state == ST_RX) begin
              next_shreg = {shreg[6:0], sda_sync[1]};
            end
            // Device holds SDA low through the ack clock
            if (state == ST_ACK && sda_sync[1]) begin
              next_nack = 1'b1;
            end
          end
          if (qtr == 2'h3) begin
            next_scl_low = 1'b1;
            case (state)
              ST_TX: begin
                next_shreg = {shreg[6:0], 1'b0};
                next_bitn  = bitn - 4'h1;
                if (bitn == 4'h1) begin
                  next_state = ST_ACK;
                end
              end
              ST_RX: begin
                next_bitn = bitn - 4'h1;
                if (bitn == 4'h1) begin
                  next_state = ST_MACK;
                end
              end
              ST_ACK: begin
                next_bitn = BYTE_BITS;
                if (nack) begin
                  next_state = ST_STOP; // Unaddressed device stays quiet
                end else if (stage == 2'h0) begin
                  next_shreg = cmd_reg;
                  next_stage = 2'h1;
                  next_state = ST_TX;
                end else if (stage == 2'h1 && is_read) begin
                  next_stage = 2'h2;
                  next_state = ST_RSTRT;
                end else if (stage == 2'h1) begin
                  next_shreg = cmd_wdata;
                  next_stage = 2'h2;
                  next_state = ST_TX;
                end else if (is_read) begin
                  next_stage = 2'h3;
                  next_state = ST_RX;
                end else begin
                  next_state = ST_STOP;
                end
              end
              default: begin
                next_rdata = shreg;
                next_state = ST_STOP;
              end
            endcase
          end
        end
      end
      ST_STOP: begin
        if (tick) begin
          next_qtr = qtr + 2'h1;
          if (qtr == 2'h0) begin
            next_sda_low = 1'b1;
          end
          if (qtr == 2'h1) begin
            next_scl_low = 1'b0;
          end
          if (qtr == 2'h2) begin
            next_sda_low = 1'b0; // SDA rises while SCL high
          end
          if (qtr == 2'h3) begin
            next_rvalid = 1'b1;
            next_state  = ST_IDLE;
          end
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    if (state == ST_RSTRT && tick && qtr == 2'h3) begin
      next_shreg = addr_byte(cmd_dev_sel, DIR_READ);
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state   <= ST_IDLE;
      qtr     <= 2'h0;
      bitn    <= 4'h0;
      stage   <= 2'h0;
      shreg   <= 8'h00;
      is_read <= 1'b0;
      scl_low <= 1'b0;
      sda_low <= 1'b0;
      rdata   <= 8'h00;
      rvalid  <= 1'b0;
      nack    <= 1'b0;
    end else begin
      state   <= next_state;
      qtr     <= next_qtr;
      bitn    <= next_bitn;
      stage   <= next_stage;
      shreg   <= next_shreg;
      is_read <= next_is_read;
      scl_low <= next_scl_low;
      sda_low <= next_sda_low;
      rdata   <= next_rdata;
      rvalid  <= next_rvalid;
      nack    <= next_nack;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  // Open drain: only ever pull low, never drive high
  assign scl_o         = 1'b0;
  assign scl_oe        = scl_low;
  assign sda_o         = 1'b0;
  assign sda_oe        = sda_low;
  assign cmd_ready     = (state == ST_IDLE);
  assign rsp_valid     = rvalid;
  assign rsp_rdata     = rdata;
  assign rsp_nack      = nack;
  // A refused address after power loss means the device must be set up again
  assign reinit_needed = nack;

  // ************************************************************
  // Checks
  // ************************************************************
  chk_sda_scl_low: assert property (@(posedge core_clk) disable iff (rst)
    (state == ST_TX && $changed(sda_oe)) |-> scl_oe)
    else $error("sda changed with scl released");
  chk_ready_idle: assert property (@(posedge core_clk) disable iff (rst)
    (cmd_valid && cmd_ready) |=> !cmd_ready)
    else $error("command not taken");
  chk_start_cond: assert property (@(posedge core_clk) disable iff (rst)
    (state == ST_START && $rose(sda_oe)) |-> !scl_oe)
    else $error("start without scl high");
  chk_rate_limit: assert property (@(posedge core_clk) disable iff (rst)
    $rose(scl_oe) |=> scl_oe [*8])
    else $error("scl low phase too short");
  // Ack clock belongs to the receiver: the master must let go of SDA
  chk_ack_release: assert property (@(posedge core_clk) disable iff (rst)
    (state == ST_ACK && qtr != 2'h0) |-> !sda_oe)
    else $error("sda held during ack clock");
  // Sampling quarter: SCL released by us and seen high, nobody stretches it
  chk_scl_released: assert property (@(posedge core_clk) disable iff (rst)
    (tick && qtr == 2'h2) |-> (!scl_oe && scl_sync[1]))
    else $error("scl low at sampling point");
  sequence seq_stop_sda_rise;
    state == ST_STOP && $fell(sda_oe);
  endsequence
  chk_stop_cond: assert property (@(posedge core_clk) disable iff (rst)
    seq_stop_sda_rise |-> !scl_oe)
    else $error("stop without scl high");
endmodule
`default_nettype wire

// [rtl/amc_pkg.sv]
/*
  Package for the amplifier control-port master: bus constants, timing, commands.
  Assumes a 100 MHz core clock and an open-drain two-wire bus with pull-ups.
*/
package amc_pkg;
  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_PERIOD_NS   = 10;
  localparam int BIT_RATE_KBPS   = 100;
  localparam int BIT_PERIOD_NS   = 1000000 / BIT_RATE_KBPS;
  // Quarter of a bit period, rounded up so the rate never exceeds the limit
  localparam int QTR_CYCLES      = (BIT_PERIOD_NS / 4 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] QTR_LAST = 8'(QTR_CYCLES - 1);
  // ************************************************************
  // Addresses and register map
  // ************************************************************
  localparam logic [4:0] DEV_ADDR_BASE   = 5'h1B;
  localparam logic [7:0] REG_STATUS_LAST = 8'h07;
  localparam logic [7:0] REG_CTRL_FIRST  = 8'h08;
  localparam logic [7:0] REG_CTRL_LAST   = 8'h0F;
  localparam logic       DIR_WRITE       = 1'b0;
  localparam logic       DIR_READ        = 1'b1;
  localparam logic [3:0] BYTE_BITS       = 4'h8;
  // ************************************************************
  // Commands at the user port
  // ************************************************************
  typedef enum logic [1:0] {
    AMC_CMD_WRITE = 2'h0,
    AMC_CMD_READ  = 2'h1
  } amc_cmd_t;
endpackage

// [rtl/amc_phase_gen.sv]
/*
  Quarter-bit tick generator for the bus master.
  Assumes it runs on core_clk; the tick paces every bus phase.
*/
`timescale 1ns/1ps
`default_nettype none
module amc_phase_gen
  import amc_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic run,
  output logic      tick
);
  logic [7:0] cnt;
  logic [7:0] next_cnt;

  always_comb begin
    next_cnt = cnt;
    if (!run || cnt == QTR_LAST) begin
      next_cnt = 8'h00;
    end else begin
      next_cnt = cnt + 8'h01;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      cnt <= 8'h00;
    end else begin
      cnt <= next_cnt;
    end
  end

  assign tick = run && (cnt == QTR_LAST);
endmodule
`default_nettype wire

// [verif/amc_dev_model.sv]
/*
  Behavioural model of the amplifier's two-wire control port and register file.
  Assumes open-drain wires resolved by the bench; the model only pulls SDA low.
*/
`timescale 1ns/1ps
`default_nettype none
module amc_dev_model #(
  parameter logic [1:0] STRAP = 2'h0
) (
  input  wire logic scl,
  input  wire logic sda,
  output logic      sda_oe
);
  // ****************************************
  // State
  // ****************************************
  logic [7:0] regs [16];
  logic [7:0] sh;
  logic [7:0] tx;
  logic [3:0] bitc;
  logic [3:0] ptr;
  logic       ps, pd, busy, is_addr, rd, first;
  initial begin
    sda_oe = 1'b0;
    {ps, pd, busy, is_addr, rd, first} = 6'h30;
    {sh, tx, bitc, ptr} = 24'h000000;
    for (int i = 0; i < 16; i++) begin
      regs[i] = (i < 8) ? 8'(8'h30 + i) : 8'h00;
    end
    regs[0] = 8'hC0; // Supply over- and undervoltage latched
  end
  // ****************************************
  // Bus engine on sampled wire edges; SCL never driven, so no stretching
  // ****************************************
  always @(scl, sda) begin
    if (ps && scl && pd && !sda) begin
      busy = 1'b1;
      bitc = 4'h0;
      is_addr = 1'b1;
      rd = 1'b0;
    end else if (ps && scl && !pd && sda) begin
      busy = 1'b0;
      sda_oe = 1'b0;
    end else if (busy && !ps && scl) begin
      if (bitc < 4'h8) begin
        sh = {sh[6:0], sda};
        bitc = bitc + 4'h1;
      end else begin
        if (rd && !is_addr && sda) busy = 1'b0;
        bitc = 4'h0;
      end
    end else if (busy && ps && !scl) begin
      sda_oe = 1'b0; // Ack released after its clock
      if (bitc == 4'h8 && (is_addr || !rd)) begin
        if (!is_addr) begin
          if (first) ptr = sh[3:0];
          else if (ptr >= 4'h8) regs[ptr] = sh;
          if (!first) ptr = ptr + 4'h1;
          first = 1'b0;
          sda_oe = 1'b1;
        end else if (sh[7:1] == {5'h1B, STRAP}) begin
          is_addr = 1'b0;
          rd = sh[0];
          first = !sh[0];
          tx = regs[ptr];
          sda_oe = 1'b1;
        end else begin
          busy = 1'b0;
        end
      end else if (rd && !is_addr && bitc < 4'h8) begin
        sda_oe = !tx[3'(4'h7 - bitc)];
      end
    end
    ps = scl;
    pd = sda;
  end
endmodule
`default_nettype wire

// [verif/tb.sv]
/*
  Testbench for the control-port master: user-side transfers against two device models.
  Assumes the models strapped to positions 0 and 3; positions 1 and 2 stay unanswered.
*/
`timescale 1ns/1ps
`default_nettype none
module tb
  import amc_pkg::*;
();
  logic       core_clk, rst, cmd_valid, cmd_ready, rsp_valid, rsp_nack;
  logic       scl_oe, sda_oe, scl_o, sda_o, reinit_needed;
  logic [1:0] cmd_op, cmd_dev_sel;
  wire  [1:0] m_oe;
  logic [7:0] cmd_reg, cmd_wdata, rsp_rdata;
  // Wired-AND with pull-ups: a line is low only while someone pulls it
  wire        scl = (scl_oe === 1'b1 && scl_o === 1'b0) ? 1'b0 : 1'b1;
  wire        sda = ((sda_oe === 1'b1 && sda_o === 1'b0) || m_oe[0] === 1'b1 || m_oe[1] === 1'b1) ? 1'b0 : 1'b1;
  int         failures = 0, total_checks = 0, starts = 0, stops = 0;
  realtime    last_rise = 0.0, min_per = 1.0e9;

  amc_i2c_master dut (.core_clk(core_clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_op(cmd_op), .cmd_dev_sel(cmd_dev_sel), .cmd_reg(cmd_reg), .cmd_wdata(cmd_wdata),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .rsp_nack(rsp_nack), .scl_i(scl), .scl_o(scl_o),
    .scl_oe(scl_oe), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .reinit_needed(reinit_needed));
  amc_dev_model #(.STRAP(2'h0)) dev_lo (.scl(scl), .sda(sda), .sda_oe(m_oe[0]));
  amc_dev_model #(.STRAP(2'h3)) dev_hi (.scl(scl), .sda(sda), .sda_oe(m_oe[1]));

  // ****************************************
  // Bus monitors
  // ****************************************
  always @(negedge sda) if (scl === 1'b1) starts++;
  always @(posedge sda) if (scl === 1'b1) stops++;
  always @(posedge scl) begin
    if (last_rise > 0.0 && $realtime - last_rise < min_per) min_per = $realtime - last_rise;
    last_rise = $realtime;
  end

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One whole transfer; a read answered by a device sees two starts
  task automatic xfer(input logic [1:0] op, input logic [1:0] sel, input logic [7:0] ra,
                      input logic [7:0] wd, input logic nk, input logic [7:0] exp);
    int n, s0, p0;
    n = 0;
    s0 = starts;
    p0 = stops;
    cmd_op = op;
    cmd_dev_sel = sel;
    cmd_reg = ra;
    cmd_wdata = wd;
    cmd_valid = 1'b1;
    do begin
      @(negedge core_clk);
      n++;
    end while (rsp_valid !== 1'b1 && n < 60000);
    cmd_valid = 1'b0;
    check("done", {7'h0, rsp_valid}, 8'h01);
    check("nack", {7'h0, rsp_nack}, {7'h0, nk});
    check("reinit", {7'h0, reinit_needed}, {7'h0, nk});
    check("starts", 8'(starts - s0), (op == AMC_CMD_READ && !nk) ? 8'h02 : 8'h01);
    check("stops", 8'(stops - p0), 8'h01);
    if (op == AMC_CMD_READ && !nk) check("rdata", rsp_rdata, exp);
    // Let an edge pass with the request low before the next call raises it
    @(negedge core_clk);
  endtask

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    rst = 1'b1;
    cmd_valid = 1'b0;
    cmd_op = 2'h0;
    cmd_dev_sel = 2'h0;
    cmd_reg = 8'h00;
    cmd_wdata = 8'h00;
    repeat (12) @(negedge core_clk);
    rst = 1'b0;
    check("bus_idle", {6'h0, scl_oe, sda_oe}, 8'h00);
    check("open_drain", {6'h0, scl_o, sda_o}, 8'h00);
    check("ready", {7'h0, cmd_ready}, 8'h01);
    $display("test reset done");
    xfer(AMC_CMD_WRITE, 2'h1, 8'h08, 8'h11, 1'b1, 8'h00);
    $display("test unanswered address done");
    xfer(AMC_CMD_WRITE, 2'h3, 8'h0F, 8'h5C, 1'b0, 8'h00);
    xfer(AMC_CMD_READ, 2'h3, 8'h0F, 8'h00, 1'b0, 8'h5C);
    $display("test write and read back done");
    xfer(AMC_CMD_READ, 2'h0, 8'h00, 8'h00, 1'b0, 8'hC0);
    $display("test fault read done");
    check("bit_rate", {7'h0, min_per >= 10000.0}, 8'h01);
    summarize;
  end

  initial begin
    #1800000;
    failures++;
    $display("BAD watchdog expected finish seen hang");
    summarize;
  end
endmodule
`default_nettype wire
